// >>> hdl/dq_pin_pkg.sv
// Shared constants and types for the serial pin front end of one memory half.
// Assumes a host quad-SPI controller drives select, serial clock and data.
package dq_pin_pkg;

  // ----------------------------------------------------------------------
  // Widths, line positions and drive masks
  // ----------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int LANES = 4;
  localparam int LINE_IN = 0;
  localparam int LINE_OUT = 1;
  localparam int LINE_WP = 2;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hf;
  localparam logic [3:0] OE_OFF = 4'h0;
  localparam logic [3:0] BITS_FULL = 4'h8;

  // ----------------------------------------------------------------------
  // Bits moved per rising edge, by lane count and data rate
  // ----------------------------------------------------------------------
  localparam logic [3:0] STEP_1_SDR = 4'h1;
  localparam logic [3:0] STEP_1_DDR = 4'h2;
  localparam logic [3:0] STEP_4_SDR = 4'h4;
  localparam logic [3:0] STEP_4_DDR = 4'h8;

  // ----------------------------------------------------------------------
  // Opcodes and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] WSR_OPCODE = 8'h01;
  localparam logic [4:0] CORE_SYNC_RST = 5'h14;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_CMD = 2'b01,
    FR_DATA = 2'b10,
    FR_BLOCK = 2'b11
  } frame_t;

  typedef struct packed {
    logic valid;
    logic instr;
    logic [7:0] data;
  } rx_beat_t;

  typedef struct packed {
    logic quad;
    logic ddr;
  } mode_t;

endpackage

// >>> hdl/sync3.sv
// Three-stage synchroniser; a change passes once stages two and three agree.
// Assumes its input is a level or a toggle from another clock or a pin.
module sync3
  import dq_pin_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter bit ASYNC = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] agree;

  // Only stage two reads stage one; the filter looks at stages two and three.
  assign agree = s2_r ~^ s3_r;

  // ----------------------------------------------------------------------
  // Stages, with a reset style chosen per clock domain
  // ----------------------------------------------------------------------
  generate
    if (ASYNC) begin : g_async
      // A link clock may stop, so its reset cannot wait for an edge.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_r <= RST_VAL;
          s2_r <= RST_VAL;
          s3_r <= RST_VAL;
          q <= RST_VAL;
        end else begin
          s1_r <= d;
          s2_r <= s1_r;
          s3_r <= s2_r;
          q <= (agree & s3_r) | (~agree & q);
        end
      end
    end else begin : g_sync
      // Free-running core clock: plain synchronous reset.
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_r <= RST_VAL;
          s2_r <= RST_VAL;
          s3_r <= RST_VAL;
          q <= RST_VAL;
        end else begin
          s1_r <= d;
          s2_r <= s1_r;
          s3_r <= s2_r;
          q <= (agree & s3_r) | (~agree & q);
        end
      end
    end
  endgenerate

endmodule

// >>> hdl/half_serial_port.sv
// Serial pin front end of one memory half: shifts bytes in and out on the
// half's own serial clock and hands them to the core on REF_CLK.
// Assumes the core answers read bytes in time and holds its mode settings
// steady while the half is selected.
//
// Function
// - SDR: command, address and write data captured on rising clock edges.
// - SDR: read data launched on falling clock edges.
// - DDR: instruction phase captured on rising edges only.
// - DDR: address and write data captured on both clock edges.
// - DDR: read data driven on both clock edges.
// - Only clock modes 0 and 3; mode 3 only with SDR.
// - Each half is timed only by its own serial clock.
// - Single mode: input on line 0, output on line 1, rising sampling in SDR.
// - Quad mode: all four lines, write-protect line included, are bidirectional.
// - Protect bit set and write-protect low: status register writes ignored.
// - Write-protect honoured only in single mode; data line in quad mode.
// - Interrupt output goes low on an uncorrectable read error.
// - Select high: standby, inputs ignored, outputs floated; frame starts on falling select.
// - Reset held: outputs floated, state cleared; resumes once released.
module half_serial_port
  import dq_pin_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic HALF2_SERIAL_CLOCK,
  input wire logic HALF2_SELECT_N,
  input wire logic [3:0] HALF2_DATA_IN,
  output logic [3:0] HALF2_DATA_OUT,
  output logic [3:0] HALF2_DATA_OE,
  input wire logic QUAD_MODE,
  input wire logic DDR_MODE,
  input wire logic PROTECT_EN,
  input wire logic ECC_FAIL,
  output rx_beat_t RX_BEAT,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic WSR_REJECT,
  output logic MODE_FAULT,
  output logic HALF2_ERROR_IRQ_N
);

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------

  // Maps the top of a shift register onto the pins for the lane count.
  function automatic logic [3:0] lanes_out(input logic [7:0] sh, input logic quad);
    if (quad) begin
      return sh[7:4];
    end
    return {2'b00, sh[7], 1'b0};
  endfunction

  // Advances a transmit register by one chunk of the current lane count.
  function automatic logic [7:0] shift_one(input logic [7:0] sh, input logic quad);
    if (quad) begin
      return {sh[3:0], 4'h0};
    end
    return {sh[6:0], 1'b0};
  endfunction

  logic hold_r;
  logic link_clr;
  mode_t mode_r;
  logic [4:0] core_s;
  logic sel_s;
  logic clk_s;
  logic wp_s;
  logic rx_s;
  logic ack_s;
  logic req_s;

  // ----------------------------------------------------------------------
  // Reset distribution
  // ----------------------------------------------------------------------

  // Registered reset; it clears the link side asynchronously because the
  // serial clock may be stopped while reset is held.
  always_ff @(posedge REF_CLK) begin
    hold_r <= RST;
  end

  // Deselect empties every frame register and floats the lines.
  assign link_clr = hold_r | HALF2_SELECT_N;

  // ----------------------------------------------------------------------
  // Link domain: receive path
  // ----------------------------------------------------------------------
  logic [3:0] fall_nib_r;
  logic [7:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic instr_r;
  logic drive_r;
  logic [7:0] rx_sh_nxt;
  logic [3:0] rx_step;
  logic [3:0] rx_cnt_nxt;
  logic rx_done;
  logic [7:0] rx_byte_r;
  logic rx_instr_r;
  logic rx_t_r;

  // Falling-edge sample, used only in the DDR data phase.
  always_ff @(negedge HALF2_SERIAL_CLOCK or posedge link_clr) begin
    if (link_clr) begin
      fall_nib_r <= 4'h0;
    end else begin
      fall_nib_r <= HALF2_DATA_IN;
    end
  end

  // Next shift value; the instruction byte never takes the falling sample.
  always_comb begin
    case ({mode_r.quad, mode_r.ddr & ~instr_r})
      2'b00: begin
        rx_sh_nxt = {rx_sh_r[6:0], HALF2_DATA_IN[LINE_IN]};
        rx_step = STEP_1_SDR;
      end
      2'b01: begin
        rx_sh_nxt = {rx_sh_r[5:0], fall_nib_r[LINE_IN], HALF2_DATA_IN[LINE_IN]};
        rx_step = STEP_1_DDR;
      end
      2'b10: begin
        rx_sh_nxt = {rx_sh_r[3:0], HALF2_DATA_IN};
        rx_step = STEP_4_SDR;
      end
      default: begin
        rx_sh_nxt = {fall_nib_r, HALF2_DATA_IN};
        rx_step = STEP_4_DDR;
      end
    endcase
    rx_cnt_nxt = rx_cnt_r + rx_step;
    rx_done = ~drive_r & (rx_cnt_nxt == BITS_FULL);
  end

  // Capture on the half's own rising edge; stops once the half drives.
  always_ff @(posedge HALF2_SERIAL_CLOCK or posedge link_clr) begin
    if (link_clr) begin
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 4'h0;
      instr_r <= 1'b1;
    end else if (!drive_r) begin
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_nxt;
      if (rx_done) begin
        instr_r <= 1'b0;
      end
    end
  end

  // Completed byte and its toggle survive deselect so the core never sees a
  // spurious event; only reset clears them.
  always_ff @(posedge HALF2_SERIAL_CLOCK or posedge hold_r) begin
    if (hold_r) begin
      rx_byte_r <= 8'h00;
      rx_instr_r <= 1'b0;
      rx_t_r <= 1'b0;
    end else if (rx_done) begin
      rx_byte_r <= rx_sh_nxt;
      rx_instr_r <= instr_r;
      rx_t_r <= ~rx_t_r;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: transmit path
  // ----------------------------------------------------------------------
  logic [7:0] tx_hold_r;
  logic tx_req_r;
  logic [7:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic tx_ack_r;
  logic [3:0] tx_step;
  logic [3:0] out_rise_r;
  logic [3:0] out_fall_r;
  logic [3:0] oe_r;

  // Request toggle from the core, brought onto the serial clock.
  sync3 #(.W(1), .RST_VAL(1'b0), .ASYNC(1'b1)) u_req_sync (
    .clk(HALF2_SERIAL_CLOCK),
    .rst(hold_r),
    .d(tx_req_r),
    .q(req_s)
  );

  assign tx_step = mode_r.quad ? (mode_r.ddr ? STEP_4_DDR : STEP_4_SDR)
                               : (mode_r.ddr ? STEP_1_DDR : STEP_1_SDR);

  // Rising edge advances the register; a new byte loads when the last chunk
  // went out. The rising-phase chunk is registered here for DDR.
  always_ff @(posedge HALF2_SERIAL_CLOCK or posedge link_clr) begin
    if (link_clr) begin
      tx_sh_r <= 8'h00;
      tx_left_r <= 4'h0;
      drive_r <= 1'b0;
      out_rise_r <= 4'h0;
    end else begin
      out_rise_r <= lanes_out(shift_one(tx_sh_r, mode_r.quad), mode_r.quad);
      if (tx_left_r > tx_step) begin
        tx_sh_r <= mode_r.ddr ? shift_one(shift_one(tx_sh_r, mode_r.quad), mode_r.quad)
                              : shift_one(tx_sh_r, mode_r.quad);
        tx_left_r <= tx_left_r - tx_step;
      end else if (req_s != tx_ack_r) begin
        tx_sh_r <= tx_hold_r;
        tx_left_r <= BITS_FULL;
        drive_r <= 1'b1;
      end else begin
        tx_left_r <= 4'h0;
      end
    end
  end

  // Acknowledge toggle; kept through deselect like the receive toggle.
  always_ff @(posedge HALF2_SERIAL_CLOCK or posedge hold_r) begin
    if (hold_r) begin
      tx_ack_r <= 1'b0;
    end else if (tx_left_r <= tx_step && req_s != tx_ack_r && !HALF2_SELECT_N) begin
      tx_ack_r <= ~tx_ack_r;
    end
  end

  // Falling edge launches data and turns the drivers on.
  always_ff @(negedge HALF2_SERIAL_CLOCK or posedge link_clr) begin
    if (link_clr) begin
      out_fall_r <= 4'h0;
      oe_r <= OE_OFF;
    end else begin
      out_fall_r <= lanes_out(tx_sh_r, mode_r.quad);
      oe_r <= drive_r ? (mode_r.quad ? OE_QUAD : OE_SINGLE) : OE_OFF;
    end
  end

  // In DDR the high phase shows the rising-edge chunk. The phase select is
  // the one gate left between flop and pin; a single flop cannot use both edges.
  assign HALF2_DATA_OUT = (mode_r.ddr & HALF2_SERIAL_CLOCK) ? out_rise_r : out_fall_r;
  assign HALF2_DATA_OE = oe_r;

  // ----------------------------------------------------------------------
  // Core domain: synchronisers and frame mode
  // ----------------------------------------------------------------------
  sync3 #(.W(5), .RST_VAL(CORE_SYNC_RST), .ASYNC(1'b0)) u_core_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({HALF2_SELECT_N, HALF2_SERIAL_CLOCK, HALF2_DATA_IN[LINE_WP], rx_t_r, tx_ack_r}),
    .q(core_s)
  );

  assign {sel_s, clk_s, wp_s, rx_s, ack_s} = core_s;

  logic sel_d_r;
  logic rx_d_r;
  logic frame_start;
  logic frame_end;
  logic rx_evt;
  logic wsr_lock;

  assign frame_start = sel_d_r & ~sel_s;
  assign frame_end = ~sel_d_r & sel_s;
  assign rx_evt = rx_s ^ rx_d_r;
  // Write-protect pin counts only in single-line mode.
  assign wsr_lock = PROTECT_EN & ~wp_s & ~mode_r.quad;

  // Edge history of the synchronised select and receive toggle.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sel_d_r <= 1'b1;
      rx_d_r <= 1'b0;
    end else begin
      sel_d_r <= sel_s;
      rx_d_r <= rx_s;
    end
  end

  // Mode is latched at frame start and held still while selected, so the
  // link side may read it directly. Idle-high clock means mode 3: SDR only.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mode_r <= '0;
      MODE_FAULT <= 1'b0;
    end else begin
      MODE_FAULT <= frame_start & DDR_MODE & clk_s;
      if (frame_start) begin
        mode_r.quad <= QUAD_MODE;
        mode_r.ddr <= DDR_MODE & ~clk_s;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Core domain: frame sequencer
  // ----------------------------------------------------------------------
  frame_t state_r;

  // Receive beats go out one cycle after the toggle is seen; a locked status
  // write is swallowed whole, its opcode included.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r <= FR_IDLE;
      RX_BEAT <= '0;
      WSR_REJECT <= 1'b0;
    end else begin
      RX_BEAT.valid <= 1'b0;
      WSR_REJECT <= 1'b0;
      if (rx_evt) begin
        RX_BEAT.data <= rx_byte_r;
        RX_BEAT.instr <= rx_instr_r;
      end
      case (state_r)
        FR_IDLE: begin
          if (frame_start) begin
            state_r <= FR_CMD;
          end
        end
        FR_CMD: begin
          if (frame_end) begin
            state_r <= FR_IDLE;
          end else if (rx_evt && rx_byte_r == WSR_OPCODE && wsr_lock) begin
            state_r <= FR_BLOCK;
            WSR_REJECT <= 1'b1;
          end else if (rx_evt) begin
            state_r <= FR_DATA;
            RX_BEAT.valid <= 1'b1;
          end
        end
        FR_DATA: begin
          if (frame_end) begin
            state_r <= FR_IDLE;
          end else if (rx_evt) begin
            RX_BEAT.valid <= 1'b1;
          end
        end
        default: begin
          if (frame_end) begin
            state_r <= FR_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Core domain: transmit handshake and error interrupt
  // ----------------------------------------------------------------------

  // The hold register stays still until the link acknowledges it.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tx_hold_r <= 8'h00;
      tx_req_r <= 1'b0;
      TX_READY <= 1'b0;
    end else if (TX_VALID && TX_READY) begin
      tx_hold_r <= TX_DATA;
      tx_req_r <= ~tx_req_r;
      TX_READY <= 1'b0;
    end else begin
      TX_READY <= (ack_s == tx_req_r);
    end
  end

  // Low from an uncorrectable error until the next frame starts; an error
  // in the same cycle as the clear wins.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      HALF2_ERROR_IRQ_N <= 1'b1;
    end else if (ECC_FAIL) begin
      HALF2_ERROR_IRQ_N <= 1'b0;
    end else if (frame_start) begin
      HALF2_ERROR_IRQ_N <= 1'b1;
    end
  end

endmodule

// >>> test/half_serial_port_assertions.sv
// Port-level checks on the half serial port.
// Assumes all checks run on REF_CLK with RST as synchronous reset.
module half_serial_port_assertions
  import dq_pin_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic HALF2_SERIAL_CLOCK,
  input wire logic HALF2_SELECT_N,
  input wire logic [3:0] HALF2_DATA_IN,
  input wire logic [3:0] HALF2_DATA_OUT,
  input wire logic [3:0] HALF2_DATA_OE,
  input wire logic QUAD_MODE,
  input wire logic DDR_MODE,
  input wire logic PROTECT_EN,
  input wire logic ECC_FAIL,
  input rx_beat_t RX_BEAT,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic WSR_REJECT,
  input wire logic MODE_FAULT,
  input wire logic HALF2_ERROR_IRQ_N
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_standby;
    HALF2_SELECT_N && $past(HALF2_SELECT_N) |-> HALF2_DATA_OE == OE_OFF;
  endproperty
  // Reset quietness is checked while reset is held, so it is never disabled.
  property p_reset;
    disable iff (1'b0) RST && $past(RST) |-> HALF2_DATA_OE == OE_OFF && !RX_BEAT.valid && HALF2_ERROR_IRQ_N;
  endproperty
  property p_oe_single;
    HALF2_DATA_OE != OE_OFF && !QUAD_MODE |-> HALF2_DATA_OE == OE_SINGLE;
  endproperty
  property p_oe_quad;
    HALF2_DATA_OE != OE_OFF && QUAD_MODE |-> HALF2_DATA_OE == OE_QUAD;
  endproperty
  property p_irq_set;
    ECC_FAIL |=> !HALF2_ERROR_IRQ_N;
  endproperty
  property p_irq_hold;
    (!HALF2_ERROR_IRQ_N && HALF2_SELECT_N) [*8] |=> !HALF2_ERROR_IRQ_N;
  endproperty
  property p_rx_in_frame;
    RX_BEAT.valid |-> !$past(HALF2_SELECT_N, 7);
  endproperty
  property p_wsr;
    WSR_REJECT |-> PROTECT_EN && !QUAD_MODE && !RX_BEAT.valid;
  endproperty
  property p_fault;
    MODE_FAULT |-> DDR_MODE;
  endproperty
  property p_own_clock;
    !$stable(HALF2_DATA_OUT) |-> !$stable(HALF2_SERIAL_CLOCK) || !$stable(HALF2_SELECT_N);
  endproperty
  a_standby: assert property (p_standby) else $error("lines driven while deselected");
  a_reset: assert property (p_reset) else $error("outputs active in reset");
  a_oe_single: assert property (p_oe_single) else $error("wrong single enables");
  a_oe_quad: assert property (p_oe_quad) else $error("wrong quad enables");
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
  a_rx_in_frame: assert property (p_rx_in_frame) else $error("byte outside frame");
  a_wsr: assert property (p_wsr) else $error("bad status write refusal");
  a_fault: assert property (p_fault) else $error("fault without double rate");
  a_own_clock: assert property (p_own_clock) else $error("output moved without clock");
  c_wsr: cover property (WSR_REJECT);
  c_fault: cover property (MODE_FAULT);
  c_instr: cover property (RX_BEAT.valid && RX_BEAT.instr);
endmodule

bind half_serial_port half_serial_port_assertions chk_u (.REF_CLK(REF_CLK), .RST(RST),
  .HALF2_SERIAL_CLOCK(HALF2_SERIAL_CLOCK), .HALF2_SELECT_N(HALF2_SELECT_N),
  .HALF2_DATA_IN(HALF2_DATA_IN), .HALF2_DATA_OUT(HALF2_DATA_OUT), .HALF2_DATA_OE(HALF2_DATA_OE),
  .QUAD_MODE(QUAD_MODE), .DDR_MODE(DDR_MODE), .PROTECT_EN(PROTECT_EN), .ECC_FAIL(ECC_FAIL),
  .RX_BEAT(RX_BEAT), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .WSR_REJECT(WSR_REJECT), .MODE_FAULT(MODE_FAULT), .HALF2_ERROR_IRQ_N(HALF2_ERROR_IRQ_N));

// >>> test/spi_host_model.sv
// Host serial controller model driving one memory half at 160 ns per clock.
// Assumes the bench resolves each line from the device enable alone and feeds it back.
module spi_host_model (
  output logic sclk,
  output logic sel_n,
  output logic [3:0] drv,
  input wire logic [3:0] lines
);
  timeunit 1ns;
  timeprecision 100ps;
  logic m3;
  // --------------------------------------------------------------
  // Frame tasks
  // --------------------------------------------------------------
  // Idle: deselected, clock standing still. Select rises just after time zero
  // so that the half sees a clean edge on its asynchronous frame clear.
  initial begin
    sclk = 1'b0;
    drv = 4'h5;
    m3 = 1'b0;
    #1;
    sel_n = 1'b1;
  end
  // The odd delay keeps the link edges at one fixed phase, clear of the REF_CLK edges.
  task automatic open(input logic mode3);
    m3 = mode3;
    sclk = mode3;
    #1.3;
    sel_n = 1'b0;
    #40;
  endtask
  // Released lines read back inverted, never the last value.
  task automatic close();
    sclk = m3;
    #40;
    sel_n = 1'b1;
    drv = ~drv;
    #200;
  endtask
  // Byte MSB first; DDR toggles the clock once per unit.
  task automatic send(input logic [7:0] b, input int w, input bit dd);
    for (int i = 8 - w; i >= 0; i -= w) begin
      if (!dd)
        sclk = 1'b0;
      if (w == 1)
        drv[0] = b[i];
      else
        drv = b[i +: 4];
      if (dd) begin
        #40;
        sclk = ~sclk;
        #40;
      end else begin
        #80;
        sclk = 1'b1;
        #80;
      end
    end
  endtask
  // Sample each unit just before the next clock edge.
  task automatic recv(input int w, input bit dd, output logic [7:0] b);
    for (int i = 8 - w; i >= 0; i -= w) begin
      if (dd)
        sclk = ~sclk;
      else
        sclk = 1'b0;
      #79;
      if (w == 1)
        b[i] = lines[1];
      else
        b[i +: 4] = lines;
      #1;
      if (!dd) begin
        sclk = 1'b1;
        #80;
      end
    end
  endtask
endmodule

// >>> test/tb_half_serial_port.sv
// Bench for the half serial port: host model on the pins, queue model of bytes.
// Assumes the design, checker and host model are compiled before it.
module tb_half_serial_port
  import dq_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic quad = 1'b0, ddr = 1'b0, prot = 1'b0, ecc = 1'b0, tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic sclk, sel_n, tx_ready, wsr, fault, irq_n;
  logic [3:0] drv, out, oe, lines;
  rx_beat_t rx;
  logic [8:0] exp_q[$];
  int fails = 0, checks_done = 0, wsr_n = 0, fault_n = 0;
  // Each line carries the device value while enabled, else the host's.
  assign lines = (oe & out) | (~oe & drv);
  // 250 MHz core clock.
  always #2 ref_clk = ~ref_clk;
  half_serial_port dut_u (.REF_CLK(ref_clk), .RST(rst), .HALF2_SERIAL_CLOCK(sclk),
    .HALF2_SELECT_N(sel_n), .HALF2_DATA_IN(lines), .HALF2_DATA_OUT(out), .HALF2_DATA_OE(oe),
    .QUAD_MODE(quad), .DDR_MODE(ddr), .PROTECT_EN(prot), .ECC_FAIL(ecc), .RX_BEAT(rx),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .WSR_REJECT(wsr),
    .MODE_FAULT(fault), .HALF2_ERROR_IRQ_N(irq_n));
  spi_host_model host_u (.sclk(sclk), .sel_n(sel_n), .drv(drv), .lines(lines));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] want, input string msg);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Every byte handed over must be the host's next byte, opcode flagged.
  // Sampled on the falling edge, away from the edge that launches the beat.
  always @(negedge ref_clk) begin
    if (rx.valid === 1'b1) begin
      check(9'(exp_q.size() != 0), 9'h001, "unexpected byte");
      if (exp_q.size() != 0)
        check({rx.instr, rx.data}, exp_q.pop_front(), "byte");
    end
    if (wsr === 1'b1)
      wsr_n++;
    if (fault === 1'b1)
      fault_n++;
  end
  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  // Mode 3 with DDR asked still runs single rate, so the host sends SDR.
  task automatic wframe(input bit m3, input bit q, input bit d, input logic [7:0] opc, input bit wp,
                        input bit keep);
    logic [7:0] b;
    @(negedge ref_clk);
    quad = q;
    ddr = d;
    host_u.open(m3);
    host_u.drv[2] = wp;
    // Expectations go in before each byte, as its beat arrives before send returns.
    if (keep)
      exp_q.push_back({1'b1, opc});
    host_u.send(opc, q ? 4 : 1, 1'b0);
    repeat (2) begin
      b = 8'($urandom);
      if (keep)
        exp_q.push_back({1'b0, b});
      host_u.send(b, q ? 4 : 1, d && !m3);
    end
    host_u.close();
    repeat (20) @(negedge ref_clk);
    check(9'(exp_q.size()), 9'h000, "bytes missing");
    $display("write frame done");
  endtask
  // The request crosses a three-stage link synchroniser, so it loads at the
  // fifth rising edge after it is offered. The offer sits between edges K-5 and
  // K-4, K being the edge that ends the last input byte: the opcode alone in
  // single SDR, the opcode and four data bytes in quad DDR (only q == d used).
  task automatic rframe(input bit q, input bit d);
    logic [7:0] b, got, opc, x;
    opc = 8'($urandom);
    b = 8'($urandom);
    @(negedge ref_clk);
    quad = q;
    ddr = d;
    host_u.open(1'b0);
    exp_q.push_back({1'b1, opc});
    fork
      begin
        host_u.send(opc, q ? 4 : 1, 1'b0);
        repeat (q ? 4 : 0) begin
          x = 8'($urandom);
          exp_q.push_back({1'b0, x});
          host_u.send(x, q ? 4 : 1, d);
        end
      end
      begin
        #((q ? 1 : 3) * 160);
        @(negedge ref_clk);
        check(9'(tx_ready), 9'h001, "hold register busy");
        tx_data = b;
        tx_valid = 1'b1;
        @(negedge ref_clk);
        tx_valid = 1'b0;
      end
    join
    host_u.recv(q ? 4 : 1, d, got);
    check(9'(got), 9'(b), "read byte");
    check(9'(oe), 9'(q ? OE_QUAD : OE_SINGLE), "read enables");
    host_u.close();
    check(9'(oe), 9'(OE_OFF), "enables after deselect");
    $display("read frame done");
  endtask
  initial begin
    void'($urandom(32'hdc46));
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (10) @(negedge ref_clk);
    // Mode 0 and 3 single, single DDR, quad SDR and quad DDR writes.
    for (int m = 0; m < 5; m++)
      wframe(m == 1, m >= 3, m == 2 || m == 4, 8'($urandom), 1'b1, 1'b1);
    prot = 1'b1;
    wframe(1'b0, 1'b0, 1'b0, WSR_OPCODE, 1'b0, 1'b0);
    check(9'(wsr_n), 9'h001, "locked status write");
    wframe(1'b0, 1'b0, 1'b0, WSR_OPCODE, 1'b1, 1'b1);
    wframe(1'b0, 1'b1, 1'b0, WSR_OPCODE, 1'b0, 1'b1);
    check(9'(wsr_n), 9'h001, "status write refused");
    prot = 1'b0;
    wframe(1'b1, 1'b0, 1'b1, 8'($urandom), 1'b1, 1'b1);
    check(9'(fault_n), 9'h001, "mode 3 with double rate");
    rframe(1'b0, 1'b0);
    rframe(1'b1, 1'b1);
    @(negedge ref_clk);
    ecc = 1'b1;
    @(negedge ref_clk);
    ecc = 1'b0;
    check(9'(irq_n), 9'h000, "interrupt raised");
    repeat (12) @(negedge ref_clk);
    check(9'(irq_n), 9'h000, "interrupt held");
    wframe(1'b0, 1'b0, 1'b0, 8'($urandom), 1'b1, 1'b1);
    check(9'(irq_n), 9'h001, "interrupt cleared");
    $display("interrupt test done");
    results();
  end
endmodule
